// >>> hw/wpss_regs.vh
// constants for the two-wire wiper position slave
// assumes a 125 MHz core clock and a bus master that owns the serial clock
//
// What this block does
// - master starts all traffic and drives clock; device only answers as slave
// - data changes only while clock low; change while high is start or stop
// - watch lines always; data fall with clock high is start; else ignore
// - transmitter releases data after eight bits; receiver pulls low on ninth
// - acknowledge matching address byte, a valid instruction byte, each data byte
// - stop after nonvolatile command launches write; address not acknowledged meanwhile
// - upper four address bits must equal the device type identifier
// - next three address bits must equal the pin_address inputs
// - address byte bit zero is direction: one read, zero write
// - instruction byte: opcode, zero, select pair, two zeros
// - read, opcode 100: return wiper position
// - write, opcode 101: load wiper position from data
// - read, opcode 101: return selected setting register
// - write, opcode 110: nonvolatile store data into selected setting
// - read, opcode 110: copy setting into wiper after settle delay
// - write, opcode 111: nonvolatile copy wiper into selected setting
// - reads and writes are four bytes; copies are two bytes
// - wiper position decodes to exactly one of 1024 taps
// - wiper is volatile and reloads from setting zero at power-up
// - four 10-bit setting registers; nonvolatile change ends within 10ms
// - setting bits nine to zero hold a position or user data
// - sample data on clock rise; change outgoing data after clock fall
// - write_guard low blocks every nonvolatile write
// - first data byte holds bits 9 and 8 low; second holds 7 to 0
`ifndef WPSS_REGS_VH
`define WPSS_REGS_VH

// instruction byte fields
`define WPSS_OP_READ_WIPER 3'h4
`define WPSS_OP_WIPER_OR_SET 3'h5
`define WPSS_OP_STORE_OR_LOAD 3'h6
`define WPSS_OP_SAVE_WIPER 3'h7

// register geometry
`define WPSS_POS_W 10
`define WPSS_TAPS 1024
`define WPSS_SETTING_INIT 10'h000
`define WPSS_WIPER_INIT 10'h000

// timing; cycle counts are sized so they meet their parameters without truncation
`define WPSS_CLK_MHZ 8'h7D
`define WPSS_NV_WRITE_US 16'h1388
`define WPSS_NV_MAX_US 16'h2710
// 5 ms of core clock at 125 MHz
`define WPSS_NV_CYCLES 21'h98968
`define WPSS_NV_CNT_W 21
`define WPSS_SETTLE_NS 8'hC8
// 200 ns of core clock at 125 MHz
`define WPSS_SETTLE_CYCLES 8'h19

`endif

// >>> hw/wpss_slave.v
// two-wire serial slave holding wiper position and four setting registers
// assumes scl/sda arrive asynchronously and are far slower than clk;
// the sda pin is open drain, resolved outside from sda_oe_b
`include "wpss_regs.vh"

module wpss_slave #(
  parameter [3:0] TYPE_ID = 4'hA, // arbitrary value
  parameter [`WPSS_NV_CNT_W-1:0] NV_WRITE_CYCLES = `WPSS_NV_CYCLES,
  parameter [7:0] SETTLE_CYCLES = `WPSS_SETTLE_CYCLES
) (
  input wire clk,
  input wire rst_b,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_b,
  input wire [2:0] pin_address,
  input wire write_guard,
  output reg [`WPSS_POS_W-1:0] wiper_position,
  output reg nv_busy,
  output reg [`WPSS_TAPS-1:0] tap_select
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_INSTR = 3'h2;
localparam [2:0] ST_DATA = 3'h3;
localparam [2:0] ST_READ = 3'h4;
localparam [2:0] ST_WAIT = 3'h5;

localparam [1:0] PEND_NONE = 2'h0;
localparam [1:0] PEND_NV = 2'h1;
localparam [1:0] PEND_COPY = 2'h2;

////////////////////////////////////////////////////////////////////////////////
// input synchronisers; first stage feeds only the second
reg [2:0] scl_s;
reg [2:0] sda_s;
reg [2:0] addr_meta;
reg [2:0] addr_sync;
reg guard_meta;
reg guard_sync;

always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    scl_s <= 3'h7;
    sda_s <= 3'h7;
    addr_meta <= 3'h0;
    addr_sync <= 3'h0;
    guard_meta <= 1'b0;
    guard_sync <= 1'b0;
  end else begin
    scl_s <= {scl_s[1:0], scl_in};
    sda_s <= {sda_s[1:0], sda_in};
    addr_meta <= pin_address;
    addr_sync <= addr_meta;
    guard_meta <= write_guard;
    guard_sync <= guard_meta;
  end
end

// edge and condition detection on the settled stages
wire scl_rise = scl_s[1] & ~scl_s[2];
wire scl_fall = ~scl_s[1] & scl_s[2];
wire scl_high = scl_s[1] & scl_s[2];
wire start_ev = scl_high & sda_s[2] & ~sda_s[1];
wire stop_ev = scl_high & ~sda_s[2] & sda_s[1];

////////////////////////////////////////////////////////////////////////////////
// protocol state
reg [2:0] state;
reg [3:0] cnt;
reg in_ack;
reg ack_ok;
reg [7:0] shift;
reg dir;
reg [2:0] op;
reg [1:0] sel;
reg [1:0] hi_bits;
reg byte_idx;
reg [9:0] rd_val;
reg [1:0] pend;
reg [9:0] pend_val;
reg [1:0] pend_sel;
reg [`WPSS_NV_CNT_W-1:0] nv_cnt;
reg [9:0] nv_val;
reg [1:0] nv_sel;
reg [7:0] settle_cnt;
reg settle_on;
reg [9:0] settle_val;
reg recall;
reg [9:0] setting [0:3];
integer k;

// instruction byte check: reserved positions zero, only six pairs defined
reg instr_ok;
always @* begin
  instr_ok = 1'b0;
  if (!shift[4] && shift[1:0] == 2'b00) begin
    case ({dir, shift[7:5]})
      {1'b1, `WPSS_OP_READ_WIPER}: instr_ok = (shift[3:2] == 2'b00);
      {1'b0, `WPSS_OP_WIPER_OR_SET}: instr_ok = (shift[3:2] == 2'b00);
      {1'b1, `WPSS_OP_WIPER_OR_SET}: instr_ok = 1'b1;
      {1'b0, `WPSS_OP_STORE_OR_LOAD}: instr_ok = 1'b1;
      {1'b1, `WPSS_OP_STORE_OR_LOAD}: instr_ok = 1'b1;
      {1'b0, `WPSS_OP_SAVE_WIPER}: instr_ok = 1'b1;
      default: instr_ok = 1'b0;
    endcase
  end
end

// address byte check; a busy part stays silent so the master can poll
wire addr_ok = (shift[7:4] == TYPE_ID)
  && (shift[3:1] == addr_sync)
  && !nv_busy;

wire active = (state != ST_IDLE) && (state != ST_WAIT);
wire is_read_op = dir && (op != `WPSS_OP_STORE_OR_LOAD);

////////////////////////////////////////////////////////////////////////////////
// main sequencer: the device never starts traffic, it only reacts to edges
always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    state <= ST_IDLE;
    cnt <= 4'h0;
    in_ack <= 1'b0;
    ack_ok <= 1'b0;
    shift <= 8'h00;
    dir <= 1'b0;
    op <= 3'h0;
    sel <= 2'h0;
    hi_bits <= 2'h0;
    byte_idx <= 1'b0;
    rd_val <= 10'h000;
    pend <= PEND_NONE;
    pend_val <= 10'h000;
    pend_sel <= 2'h0;
    nv_busy <= 1'b0;
    nv_cnt <= {`WPSS_NV_CNT_W{1'b0}};
    nv_val <= 10'h000;
    nv_sel <= 2'h0;
    settle_cnt <= 8'h00;
    settle_on <= 1'b0;
    settle_val <= 10'h000;
    recall <= 1'b1;
    wiper_position <= `WPSS_WIPER_INIT;
    sda_out <= 1'b0;
    sda_oe_b <= 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
      setting[k] <= `WPSS_SETTING_INIT;
    end
  end else begin
    // power-up recall of setting zero, once after reset release
    if (recall) begin
      recall <= 1'b0;
      wiper_position <= setting[0];
    end
    // nonvolatile write cycle; the store lands when the cycle ends
    if (nv_busy) begin
      if (nv_cnt == {{(`WPSS_NV_CNT_W-1){1'b0}}, 1'b1}) begin
        nv_busy <= 1'b0;
        setting[nv_sel] <= nv_val;
      end
      nv_cnt <= nv_cnt - {{(`WPSS_NV_CNT_W-1){1'b0}}, 1'b1};
    end
    // copy into the wiper takes effect after the settle delay
    if (settle_on) begin
      if (settle_cnt <= 8'h01) begin
        settle_on <= 1'b0;
        wiper_position <= settle_val;
      end
      settle_cnt <= settle_cnt - 8'h01;
    end
    if (start_ev) begin
      // start wins over anything in flight, including a repeated start
      state <= ST_ADDR;
      cnt <= 4'h0;
      in_ack <= 1'b0;
      pend <= PEND_NONE;
      sda_oe_b <= 1'b1;
    end else if (stop_ev) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      in_ack <= 1'b0;
      sda_oe_b <= 1'b1;
      pend <= PEND_NONE;
      // guard is looked at here so a blocked write never turns busy
      if (pend == PEND_NV && guard_sync && !nv_busy) begin
        nv_busy <= 1'b1;
        nv_cnt <= NV_WRITE_CYCLES;
        nv_val <= pend_val;
        nv_sel <= pend_sel;
      end else if (pend == PEND_COPY) begin
        settle_on <= 1'b1;
        settle_cnt <= SETTLE_CYCLES;
        settle_val <= pend_val;
      end
    end else if (active && scl_rise) begin
      // incoming bits are taken on the rising clock
      if (!in_ack && cnt < 4'h8) begin
        if (state != ST_READ) begin
          shift <= {shift[6:0], sda_s[1]};
        end
        cnt <= cnt + 4'h1;
      end else if (in_ack && state == ST_READ) begin
        ack_ok <= ~sda_s[1];
      end
    end else if (active && scl_fall) begin
      // outgoing level only changes after a falling clock
      if (!in_ack && cnt == 4'h8) begin
        in_ack <= 1'b1;
        if (state == ST_READ) begin
          sda_oe_b <= 1'b1;
        end else begin
          case (state)
            ST_ADDR: begin
              ack_ok <= addr_ok;
              sda_oe_b <= ~addr_ok;
              dir <= shift[0];
            end
            ST_INSTR: begin
              ack_ok <= instr_ok;
              sda_oe_b <= ~instr_ok;
              op <= shift[7:5];
              sel <= shift[3:2];
            end
            ST_DATA: begin
              ack_ok <= 1'b1;
              sda_oe_b <= 1'b0;
            end
            default: begin
              ack_ok <= 1'b0;
              sda_oe_b <= 1'b1;
            end
          endcase
        end
      end else if (in_ack) begin
        // end of the ninth clock: release and act on the byte
        in_ack <= 1'b0;
        cnt <= 4'h0;
        sda_oe_b <= 1'b1;
        if (!ack_ok) begin
          state <= ST_WAIT;
        end else begin
          case (state)
            ST_ADDR: state <= ST_INSTR;
            ST_INSTR: begin
              byte_idx <= 1'b0;
              if (is_read_op) begin
                state <= ST_READ;
                if (op == `WPSS_OP_READ_WIPER) begin
                  rd_val <= wiper_position;
                  shift <= {5'h00, wiper_position[9:8], 1'b0};
                end else begin
                  rd_val <= setting[sel];
                  shift <= {5'h00, setting[sel][9:8], 1'b0};
                end
                sda_oe_b <= 1'b1;
              end else if (dir) begin
                state <= ST_WAIT;
                pend <= PEND_COPY;
                pend_val <= setting[sel];
              end else if (op == `WPSS_OP_SAVE_WIPER) begin
                state <= ST_WAIT;
                pend <= PEND_NV;
                pend_val <= wiper_position;
                pend_sel <= sel;
              end else begin
                state <= ST_DATA;
              end
            end
            ST_DATA: begin
              if (!byte_idx) begin
                byte_idx <= 1'b1;
                hi_bits <= shift[1:0];
              end else begin
                state <= ST_WAIT;
                if (op == `WPSS_OP_WIPER_OR_SET) begin
                  wiper_position <= {hi_bits, shift};
                end else begin
                  pend <= PEND_NV;
                  pend_val <= {hi_bits, shift};
                  pend_sel <= sel;
                end
              end
            end
            ST_READ: begin
              if (!byte_idx) begin
                byte_idx <= 1'b1;
                shift <= {rd_val[6:0], 1'b0};
                sda_oe_b <= rd_val[7];
              end else begin
                state <= ST_WAIT;
              end
            end
            default: state <= ST_WAIT;
          endcase
        end
      end else if (state == ST_READ && cnt < 4'h8) begin
        sda_oe_b <= shift[7];
        shift <= {shift[6:0], 1'b0};
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// one tap switch per position, exactly one on at a time
genvar t;
generate
  for (t = 0; t < `WPSS_TAPS; t = t + 1) begin : g_tap
    always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        tap_select[t] <= (t == 0);
      end else begin
        tap_select[t] <= (wiper_position == t);
      end
    end
  end
endgenerate

endmodule

// >>> sim/wpss_slave_chk.sv
// checker: port assertions for the wiper position slave
// assumes it is bound onto wpss_slave and sees only its ports
//////////////////////////////////////////////////
module wpss_slave_chk #(
  parameter int NV_WRITE_CYCLES = 200
) (
  input wire clk,
  input wire rst_b,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe_b,
  input wire [9:0] wiper_position,
  input wire nv_busy,
  input wire [1023:0] tap_select
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [20:0] busy_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // length of the write cycle; a counter because the count is far beyond a repetition
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) busy_cnt <= 21'h0;
    else if (nv_busy) busy_cnt <= busy_cnt + 21'h1;
    else busy_cnt <= 21'h0;
  end
  property p_drain;
    sda_out == 1'b0;
  endproperty
  a_drain: assert property (p_drain) else $error("data pin driven high");
  property p_tap;
    tap_select == (1024'h1 << $past(wiper_position));
  endproperty
  a_tap: assert property (p_tap) else $error("tap does not follow wiper");
  property p_onehot;
    $onehot(tap_select);
  endproperty
  a_onehot: assert property (p_onehot) else $error("tap not one-hot");
  property p_busy_len;
    $fell(nv_busy) |-> busy_cnt >= NV_WRITE_CYCLES - 1 && busy_cnt <= NV_WRITE_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length");
  property p_busy_quiet;
    nv_busy && $past(nv_busy) |-> sda_oe_b;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
  property p_busy_wiper;
    nv_busy && $past(nv_busy) |-> $stable(wiper_position);
  endproperty
  a_busy_wiper: assert property (p_busy_wiper) else $error("wiper moved in write");
  property p_pull_low;
    $fell(sda_oe_b) |-> !scl_in;
  endproperty
  a_pull_low: assert property (p_pull_low) else $error("drive began clock high");
  property p_hold_ack;
    !sda_oe_b && scl_in |=> !sda_oe_b;
  endproperty
  a_hold_ack: assert property (p_hold_ack) else $error("released clock high");
endmodule
bind wpss_slave wpss_slave_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_chk (
  .clk(clk),
  .rst_b(rst_b),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe_b(sda_oe_b),
  .wiper_position(wiper_position),
  .nv_busy(nv_busy),
  .tap_select(tap_select)
);

// >>> sim/wpss_master.sv
// bus master model: bit-banged frames, 160 ns bit period
// assumes the data wire is resolved outside with a pull-up
//////////////////////////////////////////////////
module wpss_master (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  // both lines idle high; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // start, also a repeated start from the clock-low state
  task automatic start_cond();
    sda_drv = 1'b1;
    #24 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask
  // stop closes every frame
  task automatic stop_cond();
    #24 sda_drv = 1'b0;
    #56 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask
  // data moves only in the low phase, sampled in the middle of the high phase
  task automatic bit_io(input logic b, output logic r);
    // steps are whole clock periods so every pin change stays off the sampling edge
    #24 sda_drv = b;
    #56 scl = 1'b1;
    #40 r = sda_wire;
    #40 scl = 1'b0;
  endtask
  // eight bits msb first, then the ninth clock for the acknowledge
  task automatic xbyte(input logic [7:0] d, input logic nine, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(nine, r);
    ack = ~r;
  endtask
endmodule

// >>> sim/wiper_position_serial_slave_tb.sv
// testbench: commands over the two-wire bus, checks ports and read data
// assumes the master model and the bound checker
//////////////////////////////////////////////////
module wiper_position_serial_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] ID = 4'hA; // arbitrary type code
  localparam logic [2:0] PA = 3'h5;
  localparam logic [7:0] AW = {ID, PA, 1'b0};
  localparam logic [7:0] AR = {ID, PA, 1'b1};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic write_guard = 1'b1;
  logic scl;
  logic sda_drv;
  logic [9:0] got;
  logic [3:0] acks;
  wire sda_oe_b;
  wire sda_out;
  wire nv_busy;
  wire [9:0] wiper_position;
  wire [1023:0] tap_select;
  // open drain with pull-up: either party pulls low
  wire sda = sda_drv & (sda_oe_b | sda_out);
  int num_errors = 0;
  int samples_checked = 0;
  initial forever #4 clk = ~clk;
  wpss_slave #(.TYPE_ID(ID), .NV_WRITE_CYCLES(21'h0000C8), .SETTLE_CYCLES(8'h19)) i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe_b(sda_oe_b),
    .pin_address(PA),
    .write_guard(write_guard),
    .wiper_position(wiper_position),
    .nv_busy(nv_busy),
    .tap_select(tap_select)
  );
  wpss_master i_mst (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one frame of nb bytes then stop; a read acks its first byte, nacks the last
  task automatic op(input logic [7:0] ab, ib, input logic [9:0] v, input int nb);
    logic [7:0] hi;
    logic [7:0] lo;
    acks = 4'h0;
    // align to one ns after a rising edge; the master then steps in whole periods
    @(posedge clk);
    #1;
    i_mst.start_cond();
    i_mst.xbyte(ab, 1'b1, hi, acks[3]);
    if (nb > 1) i_mst.xbyte(ib, 1'b1, hi, acks[2]);
    if (nb > 2) i_mst.xbyte(ab[0] ? 8'hFF : {6'h00, v[9:8]}, ~ab[0], hi, acks[1]);
    if (nb > 3) i_mst.xbyte(ab[0] ? 8'hFF : v[7:0], 1'b1, lo, acks[0]);
    i_mst.stop_cond();
    got = {hi[1:0], lo};
  endtask
  // address polling, bounded; a write cycle that never ends is a failure
  task automatic poll();
    int n;
    for (n = 0; n < 30; n++) begin
      op(AW, 8'h00, 10'h000, 1);
      if (acks[3] === 1'b1) break;
    end
    if (n == 30) begin
      num_errors++;
      test_done();
    end
  endtask
  initial begin
    int s;
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    chk("wiper", wiper_position, 10'h000);
    chk("tap", tap_select === 1024'h1, 1'b1);
    op(AW, 8'hA0, 10'h2A5, 4);
    chk("acks", acks, 4'hF);
    chk("wiper", wiper_position, 10'h2A5);
    chk("tap", tap_select === (1024'h1 << 10'h2A5), 1'b1);
    op(AR, 8'h80, 10'h000, 4);
    chk("acks", acks, 4'hE);
    chk("read", got, 10'h2A5);
    $display("test wiper done");
    for (s = 0; s < 4; s++) begin
      op(AW, {3'h6, 1'b0, s[1:0], 2'h0}, {8'hD5, s[1:0]}, 4);
      chk("acks", acks, 4'hF);
      op(AW, 8'h00, 10'h000, 1);
      chk("poll", acks[3], 1'b0);
      poll();
      op(AR, {3'h5, 1'b0, s[1:0], 2'h0}, 10'h000, 4);
      chk("setting", got, {8'hD5, s[1:0]});
    end
    $display("test settings done");
    op(AW, 8'hE8, 10'h000, 2);
    chk("acks", acks[3:2], 2'h3);
    poll();
    op(AR, 8'hA8, 10'h000, 4);
    chk("saved", got, 10'h2A5);
    op(AR, 8'hC4, 10'h000, 2);
    chk("early", wiper_position, 10'h2A5);
    repeat (30) @(posedge clk);
    chk("recall", wiper_position, 10'h355);
    $display("test copies done");
    @(posedge clk) #1 write_guard = 1'b0;
    repeat (4) @(posedge clk);
    op(AW, 8'hCC, 10'h0AA, 4);
    op(AW, 8'h00, 10'h000, 1);
    chk("no busy", {acks[3], nv_busy}, 2'h2);
    @(posedge clk) #1 write_guard = 1'b1;
    op(AR, 8'hAC, 10'h000, 4);
    chk("kept", got, 10'h357);
    $display("test guard done");
    op(AW ^ 8'h60, 8'hA0, 10'h001, 4);
    chk("bad id", acks, 4'h0);
    op(AW ^ 8'h08, 8'hA0, 10'h001, 4);
    chk("bad pins", acks, 4'h0);
    op(AW, 8'h80, 10'h001, 4);
    chk("bad op", acks[2], 1'b0);
    op(AR, 8'hE0, 10'h001, 2);
    chk("bad op", acks[2], 1'b0);
    op(AW, 8'hA0, 10'h001, 3);
    chk("unchanged", wiper_position, 10'h355);
    $display("test refusals done");
    test_done();
  end
endmodule
